// file: rtl/hipt_host_if.sv
//
// What this block does
// - Host cycles become internal memory bus accesses
// - Select pins sampled during reset, then kept
// - 00 mux8 strobes, 01 mux16, 10 DS, 11 nonmux
// - Mode 00 with both strobes low: serial
// - Select pins weakly pulled low only in reset
// - Strobe modes use latch, read, write; DS uses strobe/direction
// - Multiplexed modes drive ready for wait states
// - Nonmux uses direction, select, acknowledge or strobe
// - Nonmux: shared pins address, port A data
// - Every memory read latches data into fast-read register
// - Direction bit one drives, zero is input
// - Port pins weakly high until direction written
// - Direction registers reset to zero
// - Pin level registers read pins, reset ones
// - Drive value registers set pin level, reset zero
//
`timescale 1ns/100ps
`default_nettype none

module hipt_host_if
    import hipt_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_hw_reset_n,
    input  wire logic        i_if_select_pin_a,
    input  wire logic        i_if_select_pin_b,
    output logic             o_sel_pull_en,
    input  wire logic        i_addr_latch,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_n,
    input  wire logic        i_data_strobe,
    input  wire logic        i_dir_read,
    input  wire logic        i_cs_n,
    input  wire logic [15:0] i_ad,
    output logic      [15:0] o_ad,
    output logic      [15:0] o_ad_oe,
    input  wire logic [7:0]  i_addr_hi,
    output logic             o_ready,
    output logic             o_transfer_ack_n,
    input  wire logic [7:0]  i_port_a,
    output logic      [7:0]  o_port_a,
    output logic      [7:0]  o_port_a_oe,
    output logic      [7:0]  o_port_a_pullup,
    input  wire logic [7:0]  i_port_b,
    output logic      [7:0]  o_port_b,
    output logic      [7:0]  o_port_b_oe,
    output logic      [7:0]  o_port_b_pullup,
    output hipt_mode_t       o_mode,
    input  wire logic        i_ser_req,
    input  wire logic        i_ser_wr,
    input  wire logic [7:0]  i_ser_addr,
    input  wire logic [15:0] i_ser_wdata,
    output logic             o_ser_done,
    output logic             o_mem_req,
    output logic             o_mem_wr,
    output logic             o_mem_wide,
    output logic      [7:0]  o_mem_addr,
    output logic      [15:0] o_mem_wdata,
    input  wire logic        i_mem_ack,
    input  wire logic [15:0] i_mem_rdata
);

    // ------------------------------------------------------------------
    // Mode capture and port register sets
    // ------------------------------------------------------------------
    hipt_mode_t mode;

    hipt_mode_latch u_mode (
        .i_sys_clk         (i_sys_clk),
        .i_rst_n           (i_rst_n),
        .i_hw_reset_n      (i_hw_reset_n),
        .i_if_select_pin_a (i_if_select_pin_a),
        .i_if_select_pin_b (i_if_select_pin_b),
        .i_rd_n            (i_rd_n),
        .i_wr_n            (i_wr_n),
        .o_sel_pull_en     (o_sel_pull_en),
        .o_mode            (mode)
    );

    assign o_mode = mode;

    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic [7:0]  reg_addr;
    logic [7:0]  a_dir;
    logic [7:0]  a_drv;
    logic [7:0]  a_lvl;
    logic        a_written;
    logic [7:0]  b_dir;
    logic [7:0]  b_drv;
    logic [7:0]  b_lvl;
    logic        b_written;

    hipt_port_regs u_port_a (
        .i_sys_clk       (i_sys_clk),
        .i_rst_n         (i_rst_n),
        .i_dir_wr        (reg_wr && reg_addr == HIPT_PORT_A_DIR_OFS),
        .i_drv_wr        (reg_wr && reg_addr == HIPT_PORT_A_DRV_OFS),
        .i_wdata         (reg_wdata),
        .i_pin_in        (i_port_a),
        .o_dir_q         (a_dir),
        .o_drv_q         (a_drv),
        .o_pin_level_q   (a_lvl),
        .o_dir_written_q (a_written)
    );

    hipt_port_regs u_port_b (
        .i_sys_clk       (i_sys_clk),
        .i_rst_n         (i_rst_n),
        .i_dir_wr        (reg_wr && reg_addr == HIPT_PORT_B_DIR_OFS),
        .i_drv_wr        (reg_wr && reg_addr == HIPT_PORT_B_DRV_OFS),
        .i_wdata         (reg_wdata),
        .i_pin_in        (i_port_b),
        .o_dir_q         (b_dir),
        .o_drv_q         (b_drv),
        .o_pin_level_q   (b_lvl),
        .o_dir_written_q (b_written)
    );

    // ------------------------------------------------------------------
    // Host cycle decode
    // ------------------------------------------------------------------
    logic        is_mux;
    logic        nonmux;
    logic        rd_act;
    logic        wr_act;
    logic        cyc;
    logic        cyc_q;
    logic        start;
    logic [7:0]  addr_q;
    logic [7:0]  cur_addr;
    logic [15:0] cur_wdata;

    assign nonmux = (mode == HIPT_MODE_NONMUX8);
    assign is_mux = (mode == HIPT_MODE_MUX8_RW) || (mode == HIPT_MODE_MUX16)
                  || (mode == HIPT_MODE_MUX8_DS);

    always_comb begin
        rd_act = 1'b0;
        wr_act = 1'b0;
        unique case (mode)
            HIPT_MODE_MUX8_RW, HIPT_MODE_MUX16: begin
                rd_act = ~i_rd_n;
                wr_act = ~i_wr_n;
            end
            HIPT_MODE_MUX8_DS: begin
                rd_act = i_data_strobe & i_dir_read;
                wr_act = i_data_strobe & ~i_dir_read;
            end
            HIPT_MODE_NONMUX8: begin
                // Asynchronous hosts tie the strobe high, so cs alone frames
                rd_act = ~i_cs_n & i_data_strobe & i_dir_read;
                wr_act = ~i_cs_n & i_data_strobe & ~i_dir_read;
            end
            HIPT_MODE_SERIAL: begin
                rd_act = i_ser_req & ~i_ser_wr;
                wr_act = i_ser_req & i_ser_wr;
            end
        endcase
    end

    assign cyc   = (rd_act | wr_act) & i_hw_reset_n;
    assign start = cyc & ~cyc_q;

    // Address tracked on each clock while the latch strobe is high, held after it falls (level-held)
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr_q <= 8'h00;
        end else if (is_mux && i_addr_latch) begin
            addr_q <= i_ad[7:0];
        end
    end

    // non-multiplexed uses shared pins as address, port A as data
    assign cur_addr  = nonmux ? i_ad[7:0]
                     : (mode == HIPT_MODE_SERIAL) ? i_ser_addr : addr_q;
    assign cur_wdata = nonmux ? {8'h00, i_port_a}
                     : (mode == HIPT_MODE_SERIAL) ? i_ser_wdata : i_ad;

    assign reg_addr  = o_mem_addr;
    assign reg_wdata = o_mem_wdata[7:0];

    // ------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------
    hipt_state_t st_q;
    logic        local_hit;
    logic [7:0]  local_rd;
    logic [15:0] rdata_q;
    logic [15:0] fast_q;
    logic [1:0]  gap_q;

    always_comb begin
        local_hit = 1'b1;
        local_rd  = 8'h00;
        unique case (o_mem_addr)
            HIPT_PORT_A_DIR_OFS: local_rd = a_dir;
            HIPT_PORT_B_DIR_OFS: local_rd = b_dir;
            HIPT_PORT_A_PIN_OFS: local_rd = a_lvl;
            HIPT_PORT_B_PIN_OFS: local_rd = b_lvl;
            HIPT_PORT_A_DRV_OFS: local_rd = a_drv;
            HIPT_PORT_B_DRV_OFS: local_rd = b_drv;
            HIPT_FAST_READ_LOW_OFS: local_rd = fast_q[7:0];
            HIPT_FAST_READ_HIGH_OFS: local_rd = fast_q[15:8];
            default: local_hit = 1'b0;
        endcase
    end

    assign reg_wr = (st_q == HIPT_ST_MEM) && o_mem_wr && local_hit;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q        <= HIPT_ST_IDLE;
            cyc_q       <= 1'b0;
            o_mem_req   <= 1'b0;
            o_mem_wr    <= 1'b0;
            o_mem_wide  <= 1'b0;
            o_mem_addr  <= 8'h00;
            o_mem_wdata <= 16'h0000;
            rdata_q     <= 16'h0000;
        end else begin
            cyc_q <= cyc;
            unique case (st_q)
                HIPT_ST_IDLE: begin
                    if (start && gap_q == 2'h0) begin
                        st_q        <= HIPT_ST_MEM;
                        o_mem_addr  <= cur_addr;
                        o_mem_wr    <= wr_act;
                        o_mem_wide  <= (mode == HIPT_MODE_MUX16);
                        o_mem_wdata <= cur_wdata;
                        o_mem_req   <= ~((cur_addr == HIPT_PORT_A_DIR_OFS)
                                      || (cur_addr == HIPT_PORT_B_DIR_OFS)
                                      || (cur_addr == HIPT_PORT_A_PIN_OFS)
                                      || (cur_addr == HIPT_PORT_B_PIN_OFS)
                                      || (cur_addr == HIPT_PORT_A_DRV_OFS)
                                      || (cur_addr == HIPT_PORT_B_DRV_OFS)
                                      || (cur_addr == HIPT_FAST_READ_LOW_OFS)
                                      || (cur_addr == HIPT_FAST_READ_HIGH_OFS));
                    end
                end
                HIPT_ST_MEM: begin
                    if (local_hit) begin
                        rdata_q <= {8'h00, local_rd};
                        st_q    <= HIPT_ST_HOLD;
                    end else if (i_mem_ack) begin
                        o_mem_req <= 1'b0;
                        rdata_q   <= i_mem_rdata;
                        st_q      <= HIPT_ST_HOLD;
                    end
                end
                HIPT_ST_HOLD: begin
                    if (!cyc) begin
                        st_q <= HIPT_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Every memory read also refreshes the fast-read register
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fast_q <= 16'h0000;
        end else if (st_q == HIPT_ST_MEM && !local_hit && i_mem_ack && !o_mem_wr) begin
            fast_q <= i_mem_rdata;
        end
    end

    // Minimum spacing between writes for hosts that ignore ready
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gap_q <= 2'h0;
        end else if (st_q == HIPT_ST_HOLD && o_mem_wr && !cyc) begin
            gap_q <= HIPT_WR_GAP;
        end else if (gap_q != 2'h0) begin
            gap_q <= gap_q - 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // Handshake and pin drive
    // ------------------------------------------------------------------
    logic done;
    logic rd_drive;

    assign done     = (st_q == HIPT_ST_HOLD);
    assign rd_drive = done && !o_mem_wr && rd_act;

    // Ready low holds the host in wait states until data is valid
    assign o_ready          = ~(is_mux && cyc && !done);
    assign o_transfer_ack_n = ~(nonmux && done && cyc);
    assign o_ser_done       = (mode == HIPT_MODE_SERIAL) && done;

    always_comb begin
        o_ad    = rdata_q;
        o_ad_oe = 16'h0000;
        if (is_mux && rd_drive) begin
            o_ad_oe = (mode == HIPT_MODE_MUX16) ? 16'hFFFF : 16'h00FF;
        end
    end

    // Port A belongs to the host bus in non-multiplexed mode
    always_comb begin
        if (nonmux) begin
            o_port_a        = rdata_q[7:0];
            o_port_a_oe     = rd_drive ? 8'hFF : 8'h00;
            o_port_a_pullup = 8'h00;
        end else begin
            o_port_a        = a_drv;
            o_port_a_oe     = a_dir;
            o_port_a_pullup = a_written ? 8'h00 : 8'hFF;
        end
    end

    assign o_port_b        = b_drv;
    assign o_port_b_oe     = b_dir;
    assign o_port_b_pullup = b_written ? 8'h00 : 8'hFF;

endmodule

`default_nettype wire

// file: rtl/hipt_mode_latch.sv
`timescale 1ns/100ps
`default_nettype none

module hipt_mode_latch
    import hipt_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_hw_reset_n,
    input  wire logic       i_if_select_pin_a,
    input  wire logic       i_if_select_pin_b,
    input  wire logic       i_rd_n,
    input  wire logic       i_wr_n,
    output logic            o_sel_pull_en,
    output hipt_mode_t      o_mode
);

    logic [1:0] sel;

    assign sel = {i_if_select_pin_b, i_if_select_pin_a};

    // Weak pulldown only while reset is held; pins float afterwards
    assign o_sel_pull_en = ~i_hw_reset_n;

    // ------------------------------------------------------------------
    // Strap capture: clocked during reset, frozen after release
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mode <= HIPT_MODE_MUX8_RW;
        end else if (!i_hw_reset_n) begin
            unique case (sel)
                HIPT_SEL_MUX8_RW: begin
                    o_mode <= (!i_rd_n && !i_wr_n) ? HIPT_MODE_SERIAL
                                                   : HIPT_MODE_MUX8_RW;
                end
                HIPT_SEL_MUX16:   o_mode <= HIPT_MODE_MUX16;
                HIPT_SEL_MUX8_DS: o_mode <= HIPT_MODE_MUX8_DS;
                HIPT_SEL_NONMUX8: o_mode <= HIPT_MODE_NONMUX8;
            endcase
        end
    end

endmodule

`default_nettype wire

// file: rtl/hipt_pkg.sv
package hipt_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] HIPT_FAST_READ_LOW_OFS  = 8'h04;
    localparam logic [7:0] HIPT_FAST_READ_HIGH_OFS = 8'h05;
    localparam logic [7:0] HIPT_PORT_A_DIR_OFS     = 8'h9F;
    localparam logic [7:0] HIPT_PORT_B_DIR_OFS     = 8'hAF;
    localparam logic [7:0] HIPT_PORT_A_PIN_OFS     = 8'hBF;
    localparam logic [7:0] HIPT_PORT_B_PIN_OFS     = 8'hCF;
    localparam logic [7:0] HIPT_PORT_A_DRV_OFS     = 8'hDF;
    localparam logic [7:0] HIPT_PORT_B_DRV_OFS     = 8'hEF;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] HIPT_DIR_RST = 8'h00;
    localparam logic [7:0] HIPT_PIN_RST = 8'hFF;
    localparam logic [7:0] HIPT_DRV_RST = 8'h00;

    // ------------------------------------------------------------------
    // Timing: write spacing for hosts without wait input, in memory clocks
    // ------------------------------------------------------------------
    localparam int unsigned HIPT_WR_GAP_CYC = 2;
    localparam logic [1:0]  HIPT_WR_GAP     = 2'(HIPT_WR_GAP_CYC);

    // ------------------------------------------------------------------
    // Interface modes, coded as {pin_b, pin_a}
    // ------------------------------------------------------------------
    localparam logic [1:0] HIPT_SEL_MUX8_RW  = 2'h0;
    localparam logic [1:0] HIPT_SEL_MUX16    = 2'h1;
    localparam logic [1:0] HIPT_SEL_MUX8_DS  = 2'h2;
    localparam logic [1:0] HIPT_SEL_NONMUX8  = 2'h3;

    typedef enum logic [4:0] {
        HIPT_MODE_MUX8_RW = 5'h01,
        HIPT_MODE_MUX16   = 5'h02,
        HIPT_MODE_MUX8_DS = 5'h04,
        HIPT_MODE_NONMUX8 = 5'h08,
        HIPT_MODE_SERIAL  = 5'h10
    } hipt_mode_t;

    typedef enum logic [2:0] {
        HIPT_ST_IDLE = 3'h1,
        HIPT_ST_MEM  = 3'h2,
        HIPT_ST_HOLD = 3'h4
    } hipt_state_t;

endpackage

// file: rtl/hipt_port_regs.sv
`timescale 1ns/100ps
`default_nettype none

module hipt_port_regs
    import hipt_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_dir_wr,
    input  wire logic       i_drv_wr,
    input  wire logic [7:0] i_wdata,
    input  wire logic [7:0] i_pin_in,
    output logic      [7:0] o_dir_q,
    output logic      [7:0] o_drv_q,
    output logic      [7:0] o_pin_level_q,
    output logic            o_dir_written_q
);

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dir_q         <= HIPT_DIR_RST;
            o_dir_written_q <= 1'b0;
        end else if (i_dir_wr) begin
            o_dir_q         <= i_wdata;
            o_dir_written_q <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_drv_q <= HIPT_DRV_RST;
        end else if (i_drv_wr) begin
            o_drv_q <= i_wdata;
        end
    end

    // Pin level is sampled every cycle; reads show the last sample
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pin_level_q <= HIPT_PIN_RST;
        end else begin
            o_pin_level_q <= i_pin_in;
        end
    end

endmodule

`default_nettype wire

// file: test/hipt_host_if_checker.sv
`timescale 1ns/100ps
`default_nettype none

module hipt_host_if_checker
    import hipt_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_hw_reset_n,
    input  wire logic        i_if_select_pin_a,
    input  wire logic        i_if_select_pin_b,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_n,
    input  wire logic        o_sel_pull_en,
    input  wire logic [15:0] o_ad_oe,
    input  wire logic        o_ready,
    input  wire logic        o_transfer_ack_n,
    input  wire logic [7:0]  o_port_b_oe,
    input  wire logic [7:0]  o_port_b_pullup,
    input  wire hipt_mode_t  o_mode,
    input  wire logic        o_mem_req,
    input  wire logic        o_mem_wr,
    input  wire logic [7:0]  o_mem_addr,
    input  wire logic        i_mem_ack
);
    // ----
    // Expected strap decode
    // ----
    logic [1:0] sel;
    logic       mux_mode;
    hipt_mode_t exp_mode;

    assign sel      = {i_if_select_pin_b, i_if_select_pin_a};
    assign mux_mode = o_mode inside {HIPT_MODE_MUX8_RW, HIPT_MODE_MUX16, HIPT_MODE_MUX8_DS};
    assign exp_mode = (sel == HIPT_SEL_MUX16) ? HIPT_MODE_MUX16 :
                      (sel == HIPT_SEL_MUX8_DS) ? HIPT_MODE_MUX8_DS :
                      (sel == HIPT_SEL_NONMUX8) ? HIPT_MODE_NONMUX8 :
                      (!i_rd_n && !i_wr_n) ? HIPT_MODE_SERIAL : HIPT_MODE_MUX8_RW;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_strap_phase;
        !i_hw_reset_n;
    endsequence
    sequence s_mem_done;
        o_mem_req && i_mem_ack && mux_mode;
    endsequence

    property p_pull;
        o_sel_pull_en == !i_hw_reset_n;
    endproperty
    property p_mode_map;
        s_strap_phase |=> o_mode == $past(exp_mode);
    endproperty
    property p_mode_keep;
        i_hw_reset_n && $past(i_hw_reset_n) |-> $stable(o_mode);
    endproperty
    property p_nonmux_addr;
        o_mode == HIPT_MODE_NONMUX8 |-> o_ad_oe == 16'h0000;
    endproperty
    property p_ready_idle;
        !mux_mode |-> o_ready;
    endproperty
    property p_ack_mode;
        o_mode != HIPT_MODE_NONMUX8 |-> o_transfer_ack_n;
    endproperty
    property p_mem_hold;
        o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_wr);
    endproperty
    property p_mem_done;
        s_mem_done |=> o_ready;
    endproperty
    property p_pull_stay;
        o_port_b_pullup == 8'h00 |=> o_port_b_pullup == 8'h00;
    endproperty
    property p_oe_written;
        o_port_b_oe != 8'h00 |-> o_port_b_pullup == 8'h00;
    endproperty

    a_pull: assert property (p_pull) else $error("select pull wrong");
    a_mode_map: assert property (p_mode_map) else $error("mode decode wrong");
    a_mode_keep: assert property (p_mode_keep) else $error("mode moved");
    a_nonmux_addr: assert property (p_nonmux_addr) else $error("address pins driven");
    a_ready_idle: assert property (p_ready_idle) else $error("ready low");
    a_ack_mode: assert property (p_ack_mode) else $error("ack outside mode");
    a_mem_hold: assert property (p_mem_hold) else $error("request dropped");
    a_mem_done: assert property (p_mem_done) else $error("no ready");
    a_pull_stay: assert property (p_pull_stay) else $error("pullup back");
    a_oe_written: assert property (p_oe_written) else $error("pullup while driving");
endmodule

bind hipt_host_if hipt_host_if_checker chk_u (
    .i_sys_clk, .i_rst_n, .i_hw_reset_n, .i_if_select_pin_a, .i_if_select_pin_b, .i_rd_n,
    .i_wr_n, .o_sel_pull_en, .o_ad_oe, .o_ready, .o_transfer_ack_n, .o_port_b_oe,
    .o_port_b_pullup, .o_mode, .o_mem_req, .o_mem_wr, .o_mem_addr, .i_mem_ack
);

`default_nettype wire

// file: test/hipt_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module hipt_host_model (
    input  wire logic        i_sys_clk,
    input  wire logic        i_ready,
    input  wire logic [7:0]  i_rdata,
    output logic             o_addr_latch,
    output logic             o_rd_n,
    output logic             o_wr_n,
    output logic      [15:0] o_ad,
    output logic             o_timeout
);
    // ----
    // Multiplexed 8-bit host with strobes
    // ----
    initial begin
        o_addr_latch = 1'b0;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_ad = 16'h0000;
        o_timeout = 1'b0;
    end

    task automatic strap(input logic rd, input logic wr);
        o_rd_n <= rd;
        o_wr_n <= wr;
    endtask

    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                          output logic [7:0] rdata);
        int k = 0;
        @(posedge i_sys_clk);
        o_ad <= {8'h00, addr};
        o_addr_latch <= 1'b1;
        @(posedge i_sys_clk);
        o_addr_latch <= 1'b0;
        @(posedge i_sys_clk);
        // On a read the bus is released, so show the inverse rather than stale data
        o_ad <= wr ? {8'h00, wdata} : ~o_ad;
        o_wr_n <= !wr;
        o_rd_n <= wr;
        do begin
            @(posedge i_sys_clk);
            k++;
        end while (i_ready !== 1'b1 && k < 64);
        o_timeout <= (k >= 64);
        rdata = i_rdata;
        o_rd_n <= 1'b1;
        o_wr_n <= 1'b1;
        o_ad <= ~o_ad;
        repeat (2) @(posedge i_sys_clk);
    endtask
endmodule

`default_nettype wire

// file: test/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb
    import hipt_pkg::*;
;
    typedef struct packed {
        logic [1:0] sel;
        logic       rd_n;
        logic       wr_n;
        hipt_mode_t mode;
    } hipt_tbrow_t;

    logic        i_sys_clk, i_rst_n, i_hw_reset_n, i_if_select_pin_a, i_if_select_pin_b;
    logic        o_sel_pull_en, i_addr_latch, i_rd_n, i_wr_n, o_ready, o_transfer_ack_n;
    logic        i_data_strobe, i_dir_read, i_cs_n, i_ser_req, i_ser_wr, h_timeout;
    logic        o_mem_req, o_mem_wr, o_mem_wide, m_wr, i_mem_ack = 1'b0;
    logic [15:0] i_ad, o_ad, o_ad_oe, h_ad, i_ser_wdata, o_mem_wdata, i_mem_rdata = 16'h0000;
    logic [7:0]  i_addr_hi, i_ser_addr, o_mem_addr, m_addr, m_wdata, ext_a, ext_b, q;
    logic [7:0]  i_port_a, o_port_a, o_port_a_oe, o_port_a_pullup;
    logic [7:0]  i_port_b, o_port_b, o_port_b_oe, o_port_b_pullup;
    logic [1:0]  mem_wait = 2'h0;
    hipt_mode_t  o_mode;
    int          mismatches = 0;
    int          tests_run = 0;
    hipt_tbrow_t rows [6] = '{
        '{2'h0, 1'b0, 1'b0, HIPT_MODE_SERIAL}, '{2'h1, 1'b1, 1'b1, HIPT_MODE_MUX16},
        '{2'h2, 1'b1, 1'b1, HIPT_MODE_MUX8_DS}, '{2'h3, 1'b1, 1'b1, HIPT_MODE_NONMUX8},
        '{2'h0, 1'b0, 1'b1, HIPT_MODE_MUX8_RW}, '{2'h0, 1'b1, 1'b1, HIPT_MODE_MUX8_RW}
    };

    hipt_host_if dut_u (
        .i_sys_clk, .i_rst_n, .i_hw_reset_n, .i_if_select_pin_a, .i_if_select_pin_b,
        .o_sel_pull_en, .i_addr_latch, .i_rd_n, .i_wr_n, .i_data_strobe, .i_dir_read,
        .i_cs_n, .i_ad, .o_ad, .o_ad_oe, .i_addr_hi, .o_ready, .o_transfer_ack_n,
        .i_port_a, .o_port_a, .o_port_a_oe, .o_port_a_pullup, .i_port_b, .o_port_b,
        .o_port_b_oe, .o_port_b_pullup, .o_mode, .i_ser_req, .i_ser_wr, .i_ser_addr,
        .i_ser_wdata, .o_ser_done(), .o_mem_req, .o_mem_wr, .o_mem_wide, .o_mem_addr,
        .o_mem_wdata, .i_mem_ack, .i_mem_rdata
    );

    hipt_host_model host_u (
        .i_sys_clk, .i_ready(o_ready), .i_rdata(i_ad[7:0]), .o_addr_latch(i_addr_latch),
        .o_rd_n(i_rd_n), .o_wr_n(i_wr_n), .o_ad(h_ad), .o_timeout(h_timeout)
    );

    // ----
    // Shared lines and memory side
    // ----
    assign i_ad     = (o_ad & o_ad_oe) | (h_ad & ~o_ad_oe);
    assign i_port_a = (o_port_a & o_port_a_oe) | (ext_a & ~o_port_a_oe);
    assign i_port_b = (o_port_b & o_port_b_oe) | (ext_b & ~o_port_b_oe);

    // Answers two cycles late; data is scrambled outside the acknowledge cycle
    always @(posedge i_sys_clk) begin
        i_mem_ack <= 1'b0;
        if (mem_wait == 2'h1) begin
            i_mem_ack <= 1'b1;
            i_mem_rdata <= {~o_mem_addr, o_mem_addr ^ 8'h5A};
            m_addr <= o_mem_addr;
            m_wr <= o_mem_wr;
            m_wdata <= o_mem_wdata[7:0];
        end else begin
            i_mem_rdata <= ~i_mem_rdata;
        end
        if (mem_wait != 2'h0) mem_wait <= mem_wait - 2'h1;
        else if (o_mem_req && !i_mem_ack) mem_wait <= 2'h2;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        host_u.access(wr, a, d, q);
        if (h_timeout) begin
            mismatches++;
            results();
        end
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk(what, 16'(exp), 16'(q));
    endtask

    initial begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end

    initial begin
        repeat (20000) @(posedge i_sys_clk);
        mismatches++;
        results();
    end

    initial begin
        {i_rst_n, i_hw_reset_n, i_if_select_pin_a, i_if_select_pin_b} = 4'h0;
        {i_data_strobe, i_dir_read, i_cs_n, i_ser_req, i_ser_wr} = 5'h0C;
        {i_addr_hi, i_ser_addr, i_ser_wdata} = 32'h0;
        ext_a = 8'h0F;
        ext_b = 8'h96;
        repeat (16) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        foreach (rows[i]) begin
            @(posedge i_sys_clk);
            i_hw_reset_n <= 1'b0;
            {i_if_select_pin_b, i_if_select_pin_a} <= rows[i].sel;
            host_u.strap(rows[i].rd_n, rows[i].wr_n);
            repeat (3) @(posedge i_sys_clk);
            chk("pull_en", 16'h1, 16'(o_sel_pull_en));
            i_hw_reset_n <= 1'b1;
            host_u.strap(1'b1, 1'b1);
            @(posedge i_sys_clk);
            {i_if_select_pin_b, i_if_select_pin_a} <= ~rows[i].sel;
            repeat (3) @(posedge i_sys_clk);
            chk("mode", 16'(rows[i].mode), 16'(o_mode));
            chk("pull_en", 16'h0, 16'(o_sel_pull_en));
        end
        chk("pullup_b", 16'hFF, 16'(o_port_b_pullup));
        chk("oe_a", 16'h0, 16'(o_port_a_oe));
        rd_chk("dir_a", HIPT_PORT_A_DIR_OFS, HIPT_DIR_RST);
        rd_chk("dir_b", HIPT_PORT_B_DIR_OFS, HIPT_DIR_RST);
        rd_chk("drv_a", HIPT_PORT_A_DRV_OFS, HIPT_DRV_RST);
        rd_chk("drv_b", HIPT_PORT_B_DRV_OFS, HIPT_DRV_RST);
        acc(1'b1, HIPT_PORT_A_DIR_OFS, 8'h5A);
        acc(1'b1, HIPT_PORT_A_DRV_OFS, 8'hC3);
        chk("oe_a", 16'h5A, 16'(o_port_a_oe));
        chk("drive_a", 16'h42, 16'(o_port_a & o_port_a_oe));
        chk("pullup_a", 16'h0, 16'(o_port_a_pullup));
        chk("pullup_b", 16'hFF, 16'(o_port_b_pullup));
        rd_chk("dir_a", HIPT_PORT_A_DIR_OFS, 8'h5A);
        rd_chk("pin_a", HIPT_PORT_A_PIN_OFS, 8'h47);
        acc(1'b1, HIPT_PORT_B_PIN_OFS, 8'h00);
        rd_chk("pin_b", HIPT_PORT_B_PIN_OFS, 8'h96);
        acc(1'b1, HIPT_PORT_B_DIR_OFS, 8'hF0);
        chk("pullup_b", 16'h0, 16'(o_port_b_pullup));
        rd_chk("pin_b", HIPT_PORT_B_PIN_OFS, 8'h06);
        rd_chk("mem_rd", 8'h31, 8'h6B);
        chk("mem_addr", 16'h3100, {m_addr, 7'h00, m_wr});
        rd_chk("fast_lo", HIPT_FAST_READ_LOW_OFS, 8'h6B);
        rd_chk("fast_hi", HIPT_FAST_READ_HIGH_OFS, 8'hCE);
        acc(1'b1, 8'h22, 8'h7E);
        chk("mem_wr", 16'h227E, {m_addr, m_wdata});
        chk("mem_dir", 16'h1, 16'(m_wr));
        chk("mem_wide", 16'h0, 16'(o_mem_wide));
        @(posedge i_sys_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        @(posedge i_sys_clk);
        chk("pullup_a", 16'hFF, 16'(o_port_a_pullup));
        rd_chk("dir_a", HIPT_PORT_A_DIR_OFS, HIPT_DIR_RST);
        results();
    end
endmodule

`default_nettype wire
